// file: ticop_top.sv
// Interrupt culling option register with Avalon-MM slave and culling outputs
`timescale 1ns/1ps
module ticop_top
#(
    parameter int CNT_W = 5
)
(
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire ticop_pkg::ticop_req_t av_req,
    output ticop_pkg::ticop_rsp_t      av_rsp,
    input  wire ticop_pkg::ticop_evt_t evt,
    output ticop_pkg::ticop_out_t      cull_out,
    output logic                      batch_mode,
    output logic                      irq
);
    import ticop_pkg::*;

    typedef struct packed {
        logic [7:0]  option;
        logic [7:0]  pending;
        logic        pend_valid;
        logic [7:0]  option0;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic        ack;
        logic [31:0] rdata;
        logic        cull;
        logic        adt1;
        logic        adt2;
        logic        irq;
        logic        waitreq;
        logic        batch;
        logic        crest_src;
        logic        valley_src;
    } ticop_st_t;

    ticop_st_t st_r;
    ticop_st_t st_nxt;

    logic             count_event;
    logic             pass_pulse;
    logic [CNT_W-1:0] count_value;
    logic             access;
    logic             wr_take;
    logic [7:0]       wbyte;

    // Elaboration check of the count field width
    if (CNT_W != TICOP_CNT_W)
    begin : g_cnt_w_check
        $error("ticop_top: CNT_W must match the register field width");
    end

    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] nw,
                                              input logic [7:0] wmask);
        merge_byte = (old & ~wmask) | (nw & wmask);
    endfunction : merge_byte

    // Event selection feeding the culling counter
    assign count_event = (st_r.option[TICOP_CREST_BIT] & evt.crest_match_event)
                       | (st_r.option[TICOP_VALLEY_BIT] & evt.valley_underflow_event);

    ticop_cull #(.CNT_W(CNT_W)) u_cull
    (
        .mclk        (mclk),
        .reset       (reset),
        .count_event (count_event),
        .cull_limit  (st_r.option[TICOP_CNT_LSB +: CNT_W]),
        .pass_pulse  (pass_pulse),
        .count_value (count_value)
    );

    // One-cycle answer: waitrequest high on first cycle, low on the second
    assign access  = (av_req.read | av_req.write) & ~st_r.ack;
    assign wr_take = av_req.write & st_r.ack & av_req.byteenable[0];
    assign wbyte   = av_req.writedata[7:0];

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.ack   = access;
        st_nxt.cull  = pass_pulse;
        // Remember which source was counted so a pass reaches the matching trigger
        st_nxt.crest_src  = st_r.option[TICOP_CREST_BIT] & evt.crest_match_event;
        st_nxt.valley_src = st_r.option[TICOP_VALLEY_BIT] & evt.valley_underflow_event;
        st_nxt.adt1  = pass_pulse & st_r.crest_src;
        st_nxt.adt2  = pass_pulse & st_r.valley_src;
        if (access)
        begin
            case (av_req.address)
                TICOP_ADDR_OPTION:  st_nxt.rdata = {24'h000000, st_r.option & TICOP_OPTION_WMASK};
                TICOP_ADDR_OPTION0: st_nxt.rdata = {24'h000000, st_r.option0};
                TICOP_ADDR_STATUS:  st_nxt.rdata = {30'h00000000, st_r.status};
                TICOP_ADDR_MASK:    st_nxt.rdata = {30'h00000000, st_r.mask};
                TICOP_ADDR_PEND:    st_nxt.rdata = {23'h000000, st_r.pend_valid, st_r.pending};
                default:            st_nxt.rdata = 32'h00000000;
            endcase
        end
        // Batch transfer point moves pending value into live register
        if (evt.transfer_point && st_r.pend_valid)
        begin
            st_nxt.option     = st_r.pending;
            st_nxt.pend_valid = 1'b0;
        end
        if (wr_take)
        begin
            case (av_req.address)
                TICOP_ADDR_OPTION:
                begin
                    if (st_r.option0[TICOP_RWMODE_BIT])
                        st_nxt.option = merge_byte(st_r.option, wbyte, TICOP_OPTION_WMASK);
                    else
                    begin
                        st_nxt.pending    = merge_byte(st_r.pend_valid ? st_r.pending : st_r.option,
                                                       wbyte, TICOP_OPTION_WMASK);
                        st_nxt.pend_valid = 1'b1;
                    end
                end
                TICOP_ADDR_OPTION0: st_nxt.option0 = merge_byte(st_r.option0, wbyte, TICOP_OPTION0_WMASK);
                TICOP_ADDR_STATUS:  st_nxt.status  = st_r.status & ~wbyte[1:0];
                TICOP_ADDR_MASK:    st_nxt.mask    = wbyte[1:0];
                default:            st_nxt.mask    = st_nxt.mask;
            endcase
        end
        // Set wins over clear
        if (pass_pulse)
            st_nxt.status[TICOP_ST_PASS] = 1'b1;
        if (evt.transfer_point && st_r.pend_valid)
            st_nxt.status[TICOP_ST_XFER] = 1'b1;
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
        st_nxt.waitreq = ~access;
        st_nxt.batch   = ~st_nxt.option0[TICOP_RWMODE_BIT];
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st_r            <= '0;
            st_r.option     <= TICOP_OPTION_RESET;
            st_r.pending    <= TICOP_OPTION_RESET;
            st_r.option0    <= TICOP_OPTION0_RESET;
            st_r.status     <= TICOP_IRQ_RESET;
            st_r.mask       <= TICOP_IRQ_RESET;
            st_r.waitreq    <= 1'b1;
            st_r.batch      <= ~TICOP_OPTION0_RESET[TICOP_RWMODE_BIT];
        end
        else
            st_r <= st_nxt;
    end

    assign av_rsp.waitrequest     = st_r.waitreq;
    assign av_rsp.readdata        = st_r.rdata;
    assign cull_out.cull_pulse    = st_r.cull;
    assign cull_out.adtrig1_pulse = st_r.adt1;
    assign cull_out.adtrig2_pulse = st_r.adt2;
    assign cull_out.cull_count    = st_r.option[TICOP_CNT_LSB +: TICOP_CNT_W];
    assign batch_mode             = st_r.batch;
    assign irq                    = st_r.irq;

    AST_RESET_CLEARS: assert property (@(posedge mclk)
        $past(reset) |-> (st_r.option == TICOP_OPTION_RESET))
        else $error("option not cleared by reset");
    AST_CREST_GATED: assert property (@(posedge mclk) disable iff (reset)
        (!st_r.option[TICOP_CREST_BIT] && !st_r.option[TICOP_VALLEY_BIT]) |-> !count_event)
        else $error("event counted while both sources disabled");
    AST_IMMEDIATE_WRITE: assert property (@(posedge mclk) disable iff (reset)
        (wr_take && av_req.address == TICOP_ADDR_OPTION && st_r.option0[TICOP_RWMODE_BIT]
         && !(evt.transfer_point && st_r.pend_valid))
        |=> (st_r.option == ($past(av_req.writedata[7:0]) & TICOP_OPTION_WMASK)))
        else $error("immediate write not applied");
    AST_BATCH_HOLD: assert property (@(posedge mclk) disable iff (reset)
        (wr_take && av_req.address == TICOP_ADDR_OPTION && !st_r.option0[TICOP_RWMODE_BIT]
         && !(evt.transfer_point && st_r.pend_valid))
        |=> st_r.pend_valid && $stable(st_r.option))
        else $error("batch write changed option before transfer");
    AST_BATCH_APPLY: assert property (@(posedge mclk) disable iff (reset)
        (evt.transfer_point && st_r.pend_valid && !wr_take) |=> (st_r.option == $past(st_r.pending)))
        else $error("pending value not applied at transfer point");
    AST_CULL_OUT: assert property (@(posedge mclk) disable iff (reset)
        pass_pulse |=> cull_out.cull_pulse)
        else $error("culling output missed pass");
    AST_RUN_WRITE: assert property (@(posedge mclk) disable iff (reset)
        (access && av_req.write && evt.timer_run_enable) |=> !av_rsp.waitrequest)
        else $error("write refused while running");
    AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (reset)
        (st_r.ack && av_req.address != TICOP_ADDR_PEND) |-> (av_rsp.readdata[31:8] == 24'h000000))
        else $error("upper read bits not zero");
    AST_WAIT_ONE: assert property (@(posedge mclk) disable iff (reset)
        access |=> !av_rsp.waitrequest)
        else $error("answer not after one cycle");
    AST_IDLE_WAIT: assert property (@(posedge mclk) disable iff (reset)
        !(av_req.read || av_req.write) |=> av_rsp.waitrequest)
        else $error("waitrequest low without a request");
    AST_ADT_WITH_CULL: assert property (@(posedge mclk) disable iff (reset)
        (cull_out.adtrig1_pulse || cull_out.adtrig2_pulse) |-> cull_out.cull_pulse)
        else $error("trigger pulse without culling pass");
    AST_ADT1_SOURCE: assert property (@(posedge mclk) disable iff (reset)
        (pass_pulse && st_r.crest_src) |=> cull_out.adtrig1_pulse)
        else $error("crest pass missed trigger one");
    AST_PASS_STATUS: assert property (@(posedge mclk) disable iff (reset)
        pass_pulse |=> st_r.status[TICOP_ST_PASS])
        else $error("pass did not set status");

endmodule : ticop_top

// file: ticop_pkg.sv
// Package: register map, field layout and carrier types of the interrupt culling option block
package ticop_pkg;

    localparam logic [3:0] TICOP_ADDR_OPTION  = 4'h0;
    localparam logic [3:0] TICOP_ADDR_OPTION0 = 4'h1;
    localparam logic [3:0] TICOP_ADDR_STATUS  = 4'h2;
    localparam logic [3:0] TICOP_ADDR_MASK    = 4'h3;
    localparam logic [3:0] TICOP_ADDR_PEND    = 4'h4;

    localparam int TICOP_CREST_BIT   = 7;
    localparam int TICOP_VALLEY_BIT  = 6;
    localparam int TICOP_CNT_LSB     = 0;
    localparam int TICOP_CNT_W       = 5;
    localparam int TICOP_RWMODE_BIT  = 0;

    localparam logic [7:0] TICOP_OPTION_RESET  = 8'h00;
    localparam logic [7:0] TICOP_OPTION_WMASK  = 8'hDF;
    localparam logic [7:0] TICOP_OPTION0_RESET = 8'h00;
    localparam logic [7:0] TICOP_OPTION0_WMASK = 8'h01;
    localparam logic [1:0] TICOP_IRQ_RESET     = 2'h0;
    localparam logic [4:0] TICOP_CNT_RESET     = 5'h00;

    // Status bits: 0 passed interrupt, 1 batch transfer done
    localparam int TICOP_ST_PASS  = 0;
    localparam int TICOP_ST_XFER  = 1;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } ticop_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } ticop_rsp_t;

    typedef struct packed {
        logic crest_match_event;
        logic valley_underflow_event;
        logic transfer_point;
        logic timer_run_enable;
    } ticop_evt_t;

    typedef struct packed {
        logic       cull_pulse;
        logic       adtrig1_pulse;
        logic       adtrig2_pulse;
        logic [4:0] cull_count;
    } ticop_out_t;

endpackage : ticop_pkg

// file: ticop_cull.sv
// Culling counter: passes one of every N+1 counted events
`timescale 1ns/1ps
module ticop_cull
#(
    parameter int CNT_W = 5
)
(
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             count_event,
    input  wire logic [CNT_W-1:0] cull_limit,
    output logic                  pass_pulse,
    output logic [CNT_W-1:0]      count_value
);
    import ticop_pkg::*;

    typedef struct packed {
        logic             pass;
        logic [CNT_W-1:0] cnt;
    } ticop_cs_t;

    ticop_cs_t st_r;
    ticop_cs_t st_nxt;

    // Elaboration check of the counter width
    if (CNT_W < 1 || CNT_W > 16)
    begin : g_cnt_w_check
        $error("ticop_cull: CNT_W out of range");
    end

    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.pass = 1'b0;
        if (count_event)
        begin
            if (st_r.cnt >= cull_limit)
            begin
                st_nxt.pass = 1'b1;
                st_nxt.cnt  = '0;
            end
            else
                st_nxt.cnt = st_r.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign pass_pulse  = st_r.pass;
    assign count_value = st_r.cnt;

    AST_ZERO_PASSES_ALL: assert property (@(posedge mclk) disable iff (reset)
        (count_event && cull_limit == '0) |=> pass_pulse)
        else $error("count zero did not pass event");
    AST_MASKED_NO_PASS: assert property (@(posedge mclk) disable iff (reset)
        (count_event && st_r.cnt < cull_limit) |=> !pass_pulse)
        else $error("masked event was passed");

endmodule : ticop_cull

// file: ticop_timer_model.sv
// Timer core model: counts up and wraps, giving crest, valley and transfer pulses
`timescale 1ns/1ps
module ticop_timer_model
(
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             run,
    input  wire logic [3:0]       period,
    output ticop_pkg::ticop_evt_t evt
);
    import ticop_pkg::*;
    logic [3:0] cnt_r;
    always_ff @(posedge mclk)
    begin
        if (reset || !run)
            cnt_r <= 4'h1;
        else
            cnt_r <= (cnt_r == period) ? 4'h0 : cnt_r + 4'h1;
    end
    always_comb
    begin
        evt.crest_match_event      = run && (cnt_r == period);
        evt.valley_underflow_event = run && (cnt_r == 4'h0);
        evt.transfer_point         = run && (cnt_r == 4'h0);
        evt.timer_run_enable       = run;
    end
endmodule : ticop_timer_model

// file: timer_interrupt_culling_option_tb_top.sv
// Testbench for the interrupt culling option block
`timescale 1ns/1ps
module timer_interrupt_culling_option_tb_top;
    import ticop_pkg::*;
    logic        mclk;
    logic        reset;
    logic        run;
    logic [3:0]  period;
    ticop_req_t  av_req;
    ticop_rsp_t  av_rsp;
    ticop_evt_t  evt;
    ticop_out_t  cull_out;
    logic        batch_mode;
    logic        irq;
    int          fail_count;
    int          num_checks;
    int          ev_n;
    int          pul_n;
    int          trig_n;
    int          e0;
    int          p0;
    int          t0;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [7:0]  opt;
    ticop_top ticop_top_i (.mclk(mclk), .reset(reset), .av_req(av_req), .av_rsp(av_rsp), .evt(evt),
                           .cull_out(cull_out), .batch_mode(batch_mode), .irq(irq));
    ticop_timer_model ticop_timer_model_i (.mclk(mclk), .reset(reset), .run(run), .period(period), .evt(evt));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        if (evt.crest_match_event && opt[7] || evt.valley_underflow_event && opt[6])
            ev_n <= ev_n + 1;
        pul_n  <= pul_n + int'(cull_out.cull_pulse === 1'b1);
        trig_n <= trig_n + int'(cull_out.adtrig1_pulse === 1'b1) + 2 * int'(cull_out.adtrig2_pulse === 1'b1);
    end
    // Weighted trigger count: crest passes count 1, valley passes 2; events alternate from a crest
    function automatic int trig_exp(input int p, input int n1, input int m);
        trig_exp = 0;
        for (int j = 1; j <= p; j++)
            trig_exp += (m == 2 || (m == 0 && (j * n1) % 2 == 0)) ? 2 : 1;
    endfunction : trig_exp
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
        int k;
        k = 0;
        av_req <= '{read: !wr, write: wr, address: a, byteenable: be, writedata: {24'h0, d}};
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (av_rsp.waitrequest !== 1'b0 && k < 20);
        rd = av_rsp.readdata;
        if (k >= 20)
        begin
            fail_count++;
            results();
        end
        av_req <= '0;
        @(posedge mclk);
    endtask : bus
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string name);
        bus(1'b0, a, 8'h00, 4'hF);
        check(name, rd, exp);
    endtask : rd_chk
    task automatic do_reset();
        reset <= 1'b1;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
    endtask : do_reset
    initial
    begin
        reset = 1'b1;
        av_req = '0;
        run = 1'b0;
        period = 4'h1;
        opt = 8'h00;
        seed = 32'h662197F1;
        {fail_count, num_checks, ev_n, pul_n, trig_n} = '0;
        do_reset();
        check("batch_mode", batch_mode, 32'h1);
        check("cull_count", cull_out.cull_count, 32'h0);
        rd_chk(TICOP_ADDR_OPTION, 32'h0, "option");
        rd_chk(4'hF, 32'h0, "unmapped");
        run <= 1'b1;
        bus(1'b1, TICOP_ADDR_OPTION0, 8'h01, 4'hF);
        check("batch_mode", batch_mode, 32'h0);
        repeat (4)
        begin
            seed = lfsr(seed);
            bus(1'b1, TICOP_ADDR_OPTION, seed[7:0], 4'hF);
            rd_chk(TICOP_ADDR_OPTION, {24'h0, seed[7:0] & TICOP_OPTION_WMASK}, "option rw");
            check("cull_count", cull_out.cull_count, seed[4:0]);
            bus(1'b1, TICOP_ADDR_OPTION, ~seed[7:0], 4'h0);
            rd_chk(TICOP_ADDR_OPTION, {24'h0, seed[7:0] & TICOP_OPTION_WMASK}, "option lane");
        end
        run <= 1'b0;
        $display("test registers done");
        for (int m = 0; m < 4; m++)
        begin
            seed = lfsr(seed);
            opt <= {m[1:0] ^ 2'h3, 1'b0, (m == 3) ? 5'h1F : (m == 0) ? 5'h00 : seed[4:0]};
            do_reset();
            bus(1'b1, TICOP_ADDR_OPTION0, 8'h01, 4'hF);
            bus(1'b1, TICOP_ADDR_OPTION, opt, 4'hF);
            bus(1'b1, TICOP_ADDR_MASK, {7'h0, m[0]}, 4'hF);
            {e0, p0, t0} = {ev_n, pul_n, trig_n};
            run <= 1'b1;
            repeat (200) @(posedge mclk);
            run <= 1'b0;
            repeat (4) @(posedge mclk);
            check("passes", pul_n - p0, (ev_n - e0) / (opt[4:0] + 1));
            check("adtrig", trig_n - t0, trig_exp((ev_n - e0) / (opt[4:0] + 1), opt[4:0] + 1, m));
            check("irq", irq, m[0] && pul_n > p0);
            bus(1'b1, TICOP_ADDR_STATUS, 8'h03, 4'hF);
            repeat (2) @(posedge mclk);
            check("irq clear", irq, 32'h0);
        end
        $display("test culling done");
        do_reset();
        opt <= 8'h00;
        seed = lfsr(seed);
        bus(1'b1, TICOP_ADDR_OPTION, seed[7:0] | 8'h01, 4'hF);
        check("held count", cull_out.cull_count, 32'h0);
        rd_chk(TICOP_ADDR_PEND, {23'h0, 1'b1, (seed[7:0] | 8'h01) & TICOP_OPTION_WMASK}, "pending");
        run <= 1'b1;
        repeat (6) @(posedge mclk);
        run <= 1'b0;
        repeat (2) @(posedge mclk);
        check("batch count", cull_out.cull_count, seed[4:0] | 5'h01);
        rd_chk(TICOP_ADDR_OPTION, {24'h0, (seed[7:0] | 8'h01) & TICOP_OPTION_WMASK}, "batch option");
        rd_chk(TICOP_ADDR_PEND, {23'h0, 1'b0, (seed[7:0] | 8'h01) & TICOP_OPTION_WMASK}, "pending done");
        $display("test batch done");
        results();
    end
endmodule : timer_interrupt_culling_option_tb_top
